// ### design/dpa_defs.svh
// Notes on behaviour
// - Write-status MOT=0 sends start, command, address, stop only.
// - Any MOT=0 request leaves I2C bus idle.
// - Command bit 12 set starts a write-status request.
// - Command bits 3:0 go into length field.
// - Deferred read may be reissued identically, then awaited.
// - Deferred read aborted by other target, write, MOT=0.
// - Identical repeated write gets ACK when write finishes.
// - Pending write aborted by other target, read, MOT=0; here stored write bytes clear only on a plain write ACK.
// - AUX cell inside or outside; uni or bidirectional.
`ifndef DPA_DEFS_SVH
`define DPA_DEFS_SVH
`define DPA_OFF_CMD 12'h100
`define DPA_OFF_WDATA 12'h104
`define DPA_OFF_ADDR 12'h108
`define DPA_OFF_STATUS 12'h10c
`define DPA_OFF_RDATA 12'h110
`define DPA_CMD_LEN_LSB 0
`define DPA_CMD_REQ_LSB 8
`define DPA_CMD_MOT_BIT 10
`define DPA_CMD_WSTAT_BIT 12
`define DPA_CMD_AONLY_BIT 13
`define DPA_CMD_MASK 32'h0000_3f0f
`define DPA_ADDR_MASK 32'h000f_ffff
`define DPA_OP_WRITE 2'h0
`define DPA_OP_READ 2'h1
`define DPA_OP_WSTAT 2'h2
`define DPA_I2C_ACK 2'h0
`define DPA_I2C_NACK 2'h1
`define DPA_I2C_DEFER 2'h2
`define DPA_RESP_OKAY 2'h0
`define DPA_RESP_SLVERR 2'h2
`define DPA_HDR_BYTES 5'h03
`endif

// ### design/dpa_pkg.sv
package dpa_pkg;
	typedef enum logic [2:0] {
		DPA_IDLE = 3'b001,
		DPA_SEND = 3'b010,
		DPA_WAIT = 3'b100
	} dpa_state_t;

	typedef enum logic [2:0] {
		DPA_RPL_NONE = 3'h0,
		DPA_RPL_ACK = 3'h1,
		DPA_RPL_NACK = 3'h2,
		DPA_RPL_DEFER = 3'h3,
		DPA_RPL_PARTIAL = 3'h4
	} dpa_reply_t;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} dpa_aux_byte_t;
endpackage : dpa_pkg

// ### design/dpa_aux_i2c.sv
`timescale 1ns/1ps
`include "dpa_defs.svh"
module dpa_aux_i2c #(
	parameter int BUF_DEPTH = 16,
	parameter bit AUX_IO_INTERNAL = 1'b1,
	parameter bit AUX_IO_BIDIR = 1'b1
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic aux_tx_valid_o,
	output dpa_pkg::dpa_aux_byte_t aux_tx_o,
	input wire logic aux_tx_ready_i,
	input wire logic aux_rx_valid_i,
	input wire dpa_pkg::dpa_aux_byte_t aux_rx_i,
	output logic aux_oe_o
);
	dpa_pkg::dpa_state_t state;
	dpa_pkg::dpa_reply_t reply;
	logic [31:0] cmd;
	logic [31:0] addr;
	logic [7:0] wbuf [BUF_DEPTH];
	logic [7:0] rbuf [BUF_DEPTH];
	logic [4:0] wptr;
	logic [4:0] rcount;
	logic [4:0] rptr;
	logic [4:0] idx;
	logic [4:0] total;
	logic [1:0] op;
	logic mot;
	logic rx_first;
	logic wr_go;
	logic rd_go;
	logic issue;
	logic [7:0] next_tx_byte;
	logic [31:0] next_rdata;
	logic [1:0] next_op;
	logic [4:0] next_total;

	function automatic logic [31:0] dpa_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res & mask;
	endfunction : dpa_merge

	// Write address and data are taken together; one beat at a time keeps decode simple
	assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o && !s_axi_awready_o;
	assign rd_go = s_axi_arvalid_i && !s_axi_rvalid_o && !s_axi_arready_o;
	// Commands written while a transaction is in flight are refused, not queued
	assign issue = wr_go && s_axi_awaddr_i == `DPA_OFF_CMD && state == dpa_pkg::DPA_IDLE;

	always_comb begin
		next_op = s_axi_wdata_i[`DPA_CMD_REQ_LSB +: 2];
		if (s_axi_wdata_i[`DPA_CMD_WSTAT_BIT]) begin
			next_op = `DPA_OP_WSTAT;
		end
		next_total = `DPA_HDR_BYTES;
		// Status and address-only requests carry no length and no data
		if (next_op != `DPA_OP_WSTAT && !s_axi_wdata_i[`DPA_CMD_AONLY_BIT]) begin
			next_total = 5'(`DPA_HDR_BYTES + 5'h01);
			if (next_op == `DPA_OP_WRITE) begin
				next_total = 5'(next_total + {1'b0, s_axi_wdata_i[3:0]} + 5'h01);
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `DPA_RESP_OKAY;
		end else begin
			s_axi_awready_o <= wr_go;
			s_axi_wready_o <= wr_go;
			if (wr_go) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= `DPA_RESP_OKAY;
				if (s_axi_awaddr_i == `DPA_OFF_CMD && state != dpa_pkg::DPA_IDLE) begin
					s_axi_bresp_o <= `DPA_RESP_SLVERR;
				end else if (s_axi_awaddr_i != `DPA_OFF_CMD && s_axi_awaddr_i != `DPA_OFF_ADDR &&
					s_axi_awaddr_i != `DPA_OFF_WDATA) begin
					s_axi_bresp_o <= `DPA_RESP_SLVERR;
				end
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd <= 32'h0000_0000;
			addr <= 32'h0000_0000;
		end else if (wr_go) begin
			if (issue) begin
				cmd <= dpa_merge(cmd, s_axi_wdata_i, 4'hf, `DPA_CMD_MASK);
			end
			if (s_axi_awaddr_i == `DPA_OFF_ADDR && state == dpa_pkg::DPA_IDLE) begin
				addr <= dpa_merge(addr, s_axi_wdata_i, s_axi_wstrb_i, `DPA_ADDR_MASK);
			end
		end
	end

	// Write bytes stay stored after a deferral so an identical retry resends them
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wptr <= 5'h00;
		end else if (state == dpa_pkg::DPA_WAIT && aux_rx_valid_i && aux_rx_i.last &&
			rx_first && op == `DPA_OP_WRITE && aux_rx_i.data[7:4] == 4'h0) begin
			// Only a lone plain ACK ends the write; a partial ACK keeps bytes for a retry
			wptr <= 5'h00;
		end else if (wr_go && s_axi_awaddr_i == `DPA_OFF_WDATA && s_axi_wstrb_i[0] &&
			state == dpa_pkg::DPA_IDLE && wptr < 5'(BUF_DEPTH)) begin
			wptr <= 5'(wptr + 5'h01);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (wr_go && s_axi_awaddr_i == `DPA_OFF_WDATA && s_axi_wstrb_i[0] &&
			state == dpa_pkg::DPA_IDLE && wptr < 5'(BUF_DEPTH)) begin
			wbuf[wptr[3:0]] <= s_axi_wdata_i[7:0];
		end
		if (state == dpa_pkg::DPA_WAIT && aux_rx_valid_i && !rx_first &&
			op == `DPA_OP_READ && rcount < 5'(BUF_DEPTH)) begin
			rbuf[rcount[3:0]] <= aux_rx_i.data;
		end
	end

	always_comb begin
		next_tx_byte = wbuf[4'(idx - 5'h04)];
		case (idx)
			5'h00: next_tx_byte = {1'b0, mot, op, addr[19:16]};
			5'h01: next_tx_byte = addr[15:8];
			5'h02: next_tx_byte = addr[7:0];
			5'h03: next_tx_byte = {4'h0, cmd[`DPA_CMD_LEN_LSB +: 4]};
			default: next_tx_byte = wbuf[4'(idx - 5'h04)];
		endcase
	end

	// Link sequencing; every accepted command is sent as a new request, whatever its target, then the reply is awaited
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= dpa_pkg::DPA_IDLE;
			idx <= 5'h00;
			total <= 5'h00;
			op <= 2'h0;
			mot <= 1'b0;
			aux_tx_valid_o <= 1'b0;
			aux_tx_o <= '0;
		end else begin
			case (state)
				dpa_pkg::DPA_IDLE: begin
					if (issue) begin
						op <= next_op;
						mot <= s_axi_wdata_i[`DPA_CMD_MOT_BIT];
						total <= next_total;
						idx <= 5'h00;
						state <= dpa_pkg::DPA_SEND;
					end
				end
				dpa_pkg::DPA_SEND: begin
					if (!aux_tx_valid_o || aux_tx_ready_i) begin
						if (idx < total) begin
							aux_tx_valid_o <= 1'b1;
							aux_tx_o.data <= next_tx_byte;
							aux_tx_o.last <= idx == 5'(total - 5'h01);
							idx <= 5'(idx + 5'h01);
						end else begin
							aux_tx_valid_o <= 1'b0;
							aux_tx_o <= '0;
							state <= dpa_pkg::DPA_WAIT;
						end
					end
				end
				dpa_pkg::DPA_WAIT: begin
					if (aux_rx_valid_i && aux_rx_i.last) begin
						state <= dpa_pkg::DPA_IDLE;
					end
				end
				default: state <= dpa_pkg::DPA_IDLE;
			endcase
		end
	end

	// AUX-level refusals count as NACK; a trailing byte on a write reply marks partial ACK
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reply <= dpa_pkg::DPA_RPL_NONE;
			rx_first <= 1'b1;
			rcount <= 5'h00;
		end else if (issue) begin
			reply <= dpa_pkg::DPA_RPL_NONE;
			rx_first <= 1'b1;
			rcount <= 5'h00;
		end else if (state == dpa_pkg::DPA_WAIT && aux_rx_valid_i) begin
			rx_first <= aux_rx_i.last;
			if (rx_first) begin
				case (aux_rx_i.data[7:6])
					`DPA_I2C_ACK: reply <= aux_rx_i.data[5:4] == 2'h0 ?
						dpa_pkg::DPA_RPL_ACK : dpa_pkg::DPA_RPL_NACK;
					`DPA_I2C_DEFER: reply <= dpa_pkg::DPA_RPL_DEFER;
					default: reply <= dpa_pkg::DPA_RPL_NACK;
				endcase
			end else if (op != `DPA_OP_READ) begin
				reply <= dpa_pkg::DPA_RPL_PARTIAL;
			end else if (rcount < 5'(BUF_DEPTH)) begin
				rcount <= 5'(rcount + 5'h01);
			end
		end
	end

	always_comb begin
		case (s_axi_araddr_i)
			`DPA_OFF_CMD: next_rdata = cmd;
			`DPA_OFF_ADDR: next_rdata = addr;
			`DPA_OFF_STATUS: next_rdata = {18'h0, wptr, rcount, reply,
				state != dpa_pkg::DPA_IDLE};
			`DPA_OFF_RDATA: next_rdata = rptr < rcount ? {24'h0, rbuf[rptr[3:0]]} : 32'h0;
			default: next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= `DPA_RESP_OKAY;
			rptr <= 5'h00;
		end else begin
			s_axi_arready_o <= rd_go;
			if (issue) begin
				rptr <= 5'h00;
			end else if (rd_go && s_axi_araddr_i == `DPA_OFF_RDATA && rptr < rcount) begin
				rptr <= 5'(rptr + 5'h01);
			end
			if (rd_go) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= next_rdata;
				s_axi_rresp_o <= (s_axi_araddr_i == `DPA_OFF_CMD || s_axi_araddr_i == `DPA_OFF_ADDR ||
					s_axi_araddr_i == `DPA_OFF_STATUS || s_axi_araddr_i == `DPA_OFF_RDATA) ?
					`DPA_RESP_OKAY : `DPA_RESP_SLVERR;
			end else if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// Unidirectional cell keeps its driver enabled; an external cell gets no enable at all
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aux_oe_o <= 1'b0;
		end else begin
			aux_oe_o <= AUX_IO_INTERNAL && (!AUX_IO_BIDIR || state == dpa_pkg::DPA_SEND);
		end
	end
endmodule : dpa_aux_i2c

// ### tb/dpa_aux_i2c_monitor.sv
`timescale 1ns/1ps
module dpa_aux_i2c_monitor (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic aux_tx_valid_o,
	input wire dpa_pkg::dpa_aux_byte_t aux_tx_o,
	input wire logic aux_tx_ready_i,
	input wire logic aux_oe_o
);
	logic [31:0] cmd;
	logic [4:0] cnt;
	wire hs = aux_tx_valid_o && aux_tx_ready_i;
	wire lst = hs && aux_tx_o.last;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	// Only accepted commands are kept, a refused one never reaches the link
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			cmd <= 32'h0;
		else if (s_axi_awready_o && s_axi_bresp_o == 2'h0 && s_axi_awaddr_i == 12'h100)
			cmd <= s_axi_wdata_i;
	end
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			cnt <= 5'h00;
		else if (hs)
			cnt <= aux_tx_o.last ? 5'h00 : cnt + 5'h01;
	end
	a_cmd_start: assert property (
		s_axi_awready_o && s_axi_bresp_o == 2'h0 && s_axi_awaddr_i == 12'h100
		|=> aux_tx_valid_o && aux_tx_o.data[6:4] == {cmd[10], cmd[12] ? 2'h2 : cmd[9:8]})
		else $error("bad request header");
	a_len_field: assert property (
		hs && cnt == 5'h03 && !cmd[12] && !cmd[13] |-> aux_tx_o.data == {4'h0, cmd[3:0]})
		else $error("bad length byte");
	a_wstat_short: assert property (lst && cmd[12] |-> cnt == 5'h02)
		else $error("status request too long");
	a_addr_only: assert property (lst && cmd[13] |-> cnt == 5'h02)
		else $error("address-only request too long");
	a_write_bytes: assert property (
		lst && cmd[13:12] == 2'h0 && cmd[9:8] == 2'h0 |-> cnt == 5'h04 + {1'b0, cmd[3:0]})
		else $error("write request length wrong");
	a_read_bytes: assert property (
		lst && cmd[13:12] == 2'h0 && cmd[9:8] == 2'h1 |-> cnt == 5'h03)
		else $error("read request length wrong");
	a_oe_drive: assert property (aux_tx_valid_o |-> aux_oe_o)
		else $error("request sent without driver enable");
	a_reply_wait: assert property (lst |=> !aux_tx_valid_o [*3])
		else $error("request sent before reply");
	a_ready_pair: assert property (s_axi_awready_o |-> s_axi_wready_o && s_axi_bvalid_o)
		else $error("write handshake outputs out of step");
endmodule : dpa_aux_i2c_monitor
bind dpa_aux_i2c dpa_aux_i2c_monitor u_mon (.mclk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awready_o,
	.s_axi_wready_o, .s_axi_bvalid_o, .s_axi_wdata_i, .s_axi_bresp_o, .aux_tx_valid_o, .aux_tx_o,
	.aux_tx_ready_i, .aux_oe_o);

// ### tb/dpa_sink_model.sv
`timescale 1ns/1ps
module dpa_sink_model (
	input wire logic mclk_i,
	input wire logic [1:0] kind_i,
	input wire logic [7:0] rdat_i,
	input wire logic tx_valid_i,
	input wire dpa_pkg::dpa_aux_byte_t tx_i,
	output logic tx_ready_o = 1'b0,
	output logic rx_valid_o = 1'b0,
	output dpa_pkg::dpa_aux_byte_t rx_o = 9'h0a5
);
	logic [7:0] req[$];
	logic [7:0] rep[$];
	int gap = 0;
	// Reply class comes from the bench: 0 ACK, 1 NACK, 2 DEFER, 3 partial ACK
	always @(posedge mclk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			req.push_back(tx_i.data);
			if (tx_i.last) begin
				rep = {};
				rep.push_back(kind_i == 2'h3 ? 8'h00 : {kind_i, 6'h00});
				if (kind_i == 2'h3)
					rep.push_back(8'h01);
				if (kind_i == 2'h0 && req[0][5:4] == 2'h1 && req.size() > 3)
					for (int i = 0; i <= req[3][3:0]; i++)
						rep.push_back(rdat_i + i[7:0]);
				req = {};
				gap = 3;
			end
		end
		#1;
		// Ready alternates so the source meets both prompt and stalled bytes
		tx_ready_o = ~tx_ready_o;
		rx_valid_o = 1'b0;
		rx_o = ~rx_o;
		if (gap > 0)
			gap--;
		else if (rep.size() > 0) begin
			rx_valid_o = 1'b1;
			rx_o = {rep.size() == 1, rep.pop_front()};
		end
	end
endmodule : dpa_sink_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic mclk_i = 1'b0, reset_n_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
	logic s_axi_bready_i = 1'b1, s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b1;
	logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, st, rd;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r, kind = 2'h0;
	logic aux_tx_valid_o, aux_tx_ready_i, aux_rx_valid_i, aux_oe_o;
	dpa_pkg::dpa_aux_byte_t aux_tx_o, aux_rx_i;
	int err_count = 0, checked = 0, cycles = 0;
	always #25 mclk_i = ~mclk_i;
	dpa_aux_i2c DUT (.mclk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
		.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .aux_tx_valid_o,
		.aux_tx_o, .aux_tx_ready_i, .aux_rx_valid_i, .aux_rx_i, .aux_oe_o);
	dpa_sink_model u_sink (.mclk_i, .kind_i(kind), .rdat_i(8'h3c), .tx_valid_i(aux_tx_valid_o),
		.tx_i(aux_tx_o), .tx_ready_o(aux_tx_ready_i), .rx_valid_o(aux_rx_valid_i), .rx_o(aux_rx_i));
	task automatic close_out();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			close_out();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h wanted %h", $time, got, exp);
		end
	endtask : check
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		#1;
		s_axi_awaddr_i = a;
		s_axi_wdata_i = d;
		s_axi_awvalid_i = 1'b1;
		s_axi_wvalid_i = 1'b1;
		do @(posedge mclk_i); while (s_axi_awready_o !== 1'b1);
		r = s_axi_bresp_o;
		#1;
		s_axi_awvalid_i = 1'b0;
		s_axi_wvalid_i = 1'b0;
	endtask : axw
	task automatic axr(input logic [11:0] a);
		@(posedge mclk_i);
		#1;
		s_axi_araddr_i = a;
		s_axi_arvalid_i = 1'b1;
		do @(posedge mclk_i); while (s_axi_arready_o !== 1'b1);
		rd = s_axi_rdata_o;
		r = s_axi_rresp_o;
		#1;
		s_axi_arvalid_i = 1'b0;
	endtask : axr
	// Poll status until the transaction is over; the timeout catches a hang
	task automatic run(input logic [31:0] c, input logic [1:0] k);
		kind = k;
		axw(12'h100, c);
		check(r, 2'h0);
		st = 32'h1;
		while (st[0] !== 1'b0) begin
			axr(12'h10c);
			st = rd;
		end
	endtask : run
	task automatic t_wstat();
		axr(12'h10c);
		check(rd, 32'h0);
		axw(12'h108, 32'h50);
		run(32'h1000, 2'h0);
		check(st[3:1], dpa_pkg::DPA_RPL_ACK);
	endtask : t_wstat
	task automatic t_read();
		run(32'h0501, 2'h2);
		check(st[3:1], dpa_pkg::DPA_RPL_DEFER);
		run(32'h0501, 2'h0);
		check(st[8:4], 5'h02);
		axr(12'h110);
		check(rd, 32'h3c);
		axr(12'h110);
		check(rd, 32'h3d);
		run(32'h0501, 2'h2);
		run(32'h2100, 2'h0);
		check({st[8:4], st[3:1]}, {5'h00, 3'h1});
	endtask : t_read
	task automatic t_write();
		axw(12'h104, 32'h5a);
		run(32'h0400, 2'h3);
		check({st[13:9], st[3:1]}, {5'h01, 3'h4});
		run(32'h1000, 2'h1);
		check(st[3:1], dpa_pkg::DPA_RPL_NACK);
		run(32'h0400, 2'h0);
		check({st[13:9], st[3:1]}, {5'h00, 3'h1});
		axw(12'h104, 32'ha5);
		run(32'h0400, 2'h2);
		run(32'h1000, 2'h0);
		check(st[3:1], dpa_pkg::DPA_RPL_ACK);
	endtask : t_write
	task automatic t_refuse();
		kind = 2'h1;
		axw(12'h100, 32'h0501);
		axw(12'h100, 32'h0501);
		check(r, 2'h2);
		// The first read is still in flight; a new command before idle would be refused
		st = 32'h1;
		while (st[0] !== 1'b0) begin
			axr(12'h10c);
			st = rd;
		end
		check(st[3:1], dpa_pkg::DPA_RPL_NACK);
		run(32'h1000, 2'h1);
		axw(12'h200, 32'h1);
		check(r, 2'h2);
		axr(12'h200);
		check(rd, 32'h0);
		check(r, 2'h2);
	endtask : t_refuse
	initial begin
		repeat (6) @(posedge mclk_i);
		#1;
		reset_n_i = 1'b1;
		t_wstat();
		t_read();
		t_write();
		t_refuse();
		close_out();
	end
endmodule : testbench
